// File: logic/sral_top.sv
// Receive frame alignment, loss-of-signal mute and byte output.
// Assumes the serial link clock is much slower than i_core_clk.
`timescale 1ns/10ps
`include "sral_defs.svh"
module sral_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Serial link
  input wire logic i_rx_serial_clk,
  input wire logic i_rx_serial_data,
  // Control pins
  input wire logic i_out_of_frame_request,
  input wire logic i_los_detect_disable,
  input wire logic i_optical_signal_lost_n,
  input wire logic i_line_rate_select,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Parallel output
  output logic [7:0] o_rx_parallel_out,
  output logic o_rx_byte_clock_out,
  output logic o_frame_sync_pulse,
  // Status
  output logic o_line_rate_sts12,
  output logic o_los,
  output logic o_irq
);

  logic [`SRAL_PIN_NUM-1:0] pins;
  logic [`SRAL_PIN_NUM-1:0] sync1;
  logic [`SRAL_PIN_NUM-1:0] sync2;
  logic clk_prev;
  logic bit_stb;
  logic bit_val;
  logic [15:0] sr;
  logic [15:0] next_sr;
  logic [7:0] next_byte;
  logic [7:0] hold;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic byte_end;
  logic upd;
  logic match;
  logic realign;
  logic [1:0] a2_cnt;
  logic frame_arm;
  logic frame_found;
  logic locked;
  logic mute;
  logic out_of_frame_request;
  logic los_dis;
  logic ext_ok;
  logic los;
  logic los_prev;
  logic [`SRAL_EV_NUM-1:0] status;
  logic [`SRAL_EV_NUM-1:0] enable;
  logic [`SRAL_EV_NUM-1:0] events;
  logic [`SRAL_EV_NUM-1:0] clr;
  sral_pkg::sral_frame_state_t state;

  sral_bit_if bif ();

  assign pins = {i_line_rate_select, i_optical_signal_lost_n, i_los_detect_disable,
                 i_out_of_frame_request, i_rx_serial_data, i_rx_serial_clk};

  // Two-stage synchronisers on every pin
  genvar g;
  generate
    for (g = 0; g < `SRAL_PIN_NUM; g++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  assign out_of_frame_request = sync2[`SRAL_PIN_OOF];
  assign los_dis = sync2[`SRAL_PIN_DIS];
  assign ext_ok = sync2[`SRAL_PIN_EXTN];

  // Bit taken on each rising link clock edge
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_prev <= 1'b0;
      bit_stb <= 1'b0;
      bit_val <= 1'b0;
    end else begin
      clk_prev <= sync2[`SRAL_PIN_CLK];
      bit_stb <= sync2[`SRAL_PIN_CLK] & ~clk_prev;
      bit_val <= sync2[`SRAL_PIN_DATA];
    end
  end

  assign bif.bit_stb = bit_stb;
  assign bif.bit_val = bit_val;
  assign bif.los_disable = los_dis;
  assign los = bif.los;

  sral_los_detect sral_los_detect_inst (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .bus(bif.detector)
  );

  assign next_sr = {sr[14:0], bit_val};
  assign next_byte = next_sr[7:0];
  assign byte_end = bit_stb && bit_cnt == `SRAL_BIT_LAST;
  // Sliding match covers every bit offset
  assign match = next_sr == {`SRAL_A1, `SRAL_A2};
  assign realign = bit_stb && out_of_frame_request && state == sral_pkg::SRAL_HUNT && match;
  assign next_bit_cnt = realign ? `SRAL_BIT_FIRST : bit_cnt + 1'b1;
  // Data moves only where the byte clock falls
  assign upd = bit_stb && next_bit_cnt == `SRAL_BIT_HALF;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sr <= '0;
    end else if (bit_stb) begin
      sr <= next_sr;
    end
  end

  // Byte boundary moves to the recovered frame
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt <= `SRAL_BIT_FIRST;
    end else if (bit_stb) begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // First received bit lands in bit 7
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold <= '0;
    end else if (byte_end) begin
      hold <= next_byte;
    end
  end

  // Search runs only while the framer asks
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= sral_pkg::SRAL_IDLE;
      a2_cnt <= '0;
      frame_found <= 1'b0;
    end else begin
      frame_found <= 1'b0;
      if (!out_of_frame_request) begin
        state <= sral_pkg::SRAL_IDLE;
      end else begin
        unique case (state)
          sral_pkg::SRAL_IDLE: begin
            state <= sral_pkg::SRAL_HUNT;
          end
          sral_pkg::SRAL_HUNT: begin
            if (realign) begin
              a2_cnt <= `SRAL_A2_FIRST;
              state <= sral_pkg::SRAL_A2;
            end
          end
          sral_pkg::SRAL_A2: begin
            if (byte_end) begin
              if (next_byte != `SRAL_A2) begin
                state <= sral_pkg::SRAL_HUNT;
              end else if (a2_cnt == `SRAL_A2_BEFORE_LAST) begin
                frame_found <= 1'b1;
                state <= sral_pkg::SRAL_HUNT;
              end else begin
                a2_cnt <= a2_cnt + 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      locked <= 1'b0;
    end else if (frame_found) begin
      locked <= 1'b1;
    end else if (realign) begin
      locked <= 1'b0;
    end
  end

  // Pulse lines up with the third A2 on the bus
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_arm <= 1'b0;
      o_frame_sync_pulse <= 1'b0;
    end else begin
      if (frame_found) begin
        frame_arm <= 1'b1;
      end else if (upd) begin
        frame_arm <= 1'b0;
      end
      if (upd) begin
        o_frame_sync_pulse <= frame_arm;
      end
    end
  end

  // Byte clock high for bits 0..3, falls as data changes
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_byte_clock_out <= 1'b0;
    end else if (bit_stb) begin
      o_rx_byte_clock_out <= next_bit_cnt < `SRAL_BIT_HALF;
    end
  end

  // Internal loss mutes only when monitoring on
  assign mute = (los && !los_dis) || !ext_ok;

  // Output held at zero while loss persists
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_parallel_out <= '0;
    end else if (mute) begin
      o_rx_parallel_out <= '0;
    end else if (upd) begin
      o_rx_parallel_out <= hold;
    end
  end

  // Line rate reported from the select pin
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_line_rate_sts12 <= 1'b0;
      o_los <= 1'b0;
    end else begin
      o_line_rate_sts12 <= sync2[`SRAL_PIN_RATE];
      o_los <= los;
    end
  end

  // Events and sticky status, set wins over clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      los_prev <= 1'b0;
    end else begin
      los_prev <= los;
    end
  end

  assign events[`SRAL_EV_FRAME] = frame_found;
  assign events[`SRAL_EV_LOS_SET] = los & ~los_prev;
  assign events[`SRAL_EV_LOS_CLR] = ~los & los_prev;
  assign clr = (i_wr && i_addr == `SRAL_ADDR_CLEAR) ? i_wdata[`SRAL_EV_NUM-1:0] : '0;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | events;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable <= '0;
    end else if (i_wr && i_addr == `SRAL_ADDR_ENABLE) begin
      enable <= i_wdata[`SRAL_EV_NUM-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & enable);
    end
  end

  // Read data, zero for unmapped and write-only
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        `SRAL_ADDR_STATUS: o_rdata <= 32'(status);
        `SRAL_ADDR_ENABLE: o_rdata <= 32'(enable);
        `SRAL_ADDR_STATE: o_rdata <= 32'({mute, o_line_rate_sts12, locked, los, out_of_frame_request});
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  a_pulse_from_arm: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    upd |=> o_frame_sync_pulse == $past(frame_arm))
    else $error("frame pulse does not follow armed third A2");

  a_third_a2_only: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    frame_found |-> $past(state) == sral_pkg::SRAL_A2 && $past(a2_cnt) == `SRAL_A2_BEFORE_LAST
      && $past(out_of_frame_request))
    else $error("frame found without three A2 bytes");

  a_realign_boundary: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    realign |=> bit_cnt == `SRAL_BIT_FIRST && state == sral_pkg::SRAL_A2)
    else $error("byte boundary not moved on framing match");

  a_mute_external: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !ext_ok |=> o_rx_parallel_out == 8'h00)
    else $error("output not zero while external signal lost");

  a_mute_los: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    los && !los_dis |=> o_rx_parallel_out == 8'h00)
    else $error("output not zero during loss of signal");

  a_output_update: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    upd && !mute |=> o_rx_parallel_out == $past(hold) && !o_rx_byte_clock_out)
    else $error("byte not presented on byte clock fall");

  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    |(status & enable) |=> o_irq)
    else $error("interrupt not raised for enabled status");

  a_rate_follow: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ##1 o_line_rate_sts12 == $past(sync2[`SRAL_PIN_RATE]))
    else $error("line rate indication does not follow select");

  c_frame_pulse: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(o_frame_sync_pulse));
  c_ext_mute: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(ext_ok));

endmodule : sral_top

// File: logic/sral_defs.svh
// Constants for the receive alignment and loss-of-signal block.
// Assumes a single core clock that oversamples the serial link clock.
//
// Functional notes
// - Pulse one byte period on third A2
// - Output bytes aligned to recovered frame
// - Declare LOS after 128 zero bits
// - Clear LOS on 16 transitions/128 bits
// - Disable input turns off LOS monitor, mute
// - External signal lost forces output zero
// - Rate select: low STS-3, high STS-12
// - Serial stream converted to 8-bit bytes
// - Bytes change together, first bit in bit7
// - Output zero whole time LOS persists
`ifndef SRAL_DEFS_SVH
`define SRAL_DEFS_SVH

// Framing bytes
`define SRAL_A1 8'hf6
`define SRAL_A2 8'h28
// Third A2 reached when count of earlier ones is two
`define SRAL_A2_BEFORE_LAST 2'h2
`define SRAL_A2_FIRST 2'h1

// Bit positions within a byte period
`define SRAL_BIT_FIRST 3'h0
`define SRAL_BIT_LAST 3'h7
`define SRAL_BIT_HALF 3'h4
`define SRAL_BIT_FALL 3'h3

// Loss-of-signal figures
`define SRAL_LOS_ZERO_RUN 128
`define SRAL_LOS_WINDOW 128
`define SRAL_LOS_MIN_TRANS 16

// Register byte addresses
`define SRAL_ADDR_STATUS 4'h0
`define SRAL_ADDR_CLEAR 4'h4
`define SRAL_ADDR_ENABLE 4'h8
`define SRAL_ADDR_STATE 4'hc

// Event bits
`define SRAL_EV_FRAME 0
`define SRAL_EV_LOS_SET 1
`define SRAL_EV_LOS_CLR 2
`define SRAL_EV_NUM 3

// Synchronised pin index
`define SRAL_PIN_CLK 0
`define SRAL_PIN_DATA 1
`define SRAL_PIN_OOF 2
`define SRAL_PIN_DIS 3
`define SRAL_PIN_EXTN 4
`define SRAL_PIN_RATE 5
`define SRAL_PIN_NUM 6

`endif

// File: logic/sral_pkg.sv
// Types for the receive alignment block.
// Assumes sral_defs.svh is included by the modules that need numbers.
package sral_pkg;

  typedef enum logic [1:0] {
    SRAL_IDLE,
    SRAL_HUNT,
    SRAL_A2
  } sral_frame_state_t;

endpackage : sral_pkg

// File: logic/sral_bit_if.sv
// Carrier between the top and the loss-of-signal detector.
// Assumes both ends share i_core_clk.
`timescale 1ns/10ps
interface sral_bit_if;
  logic bit_stb;
  logic bit_val;
  logic los_disable;
  logic los;

  modport source (output bit_stb, output bit_val, output los_disable, input los);
  modport detector (input bit_stb, input bit_val, input los_disable, output los);
endinterface : sral_bit_if

// File: logic/sral_los_detect.sv
// Loss-of-signal detector on the recovered bit stream.
// Assumes one bit strobe per serial bit, on the core clock.
`timescale 1ns/10ps
`include "sral_defs.svh"
module sral_los_detect #(
  parameter int ZERO_RUN = `SRAL_LOS_ZERO_RUN,
  parameter int WINDOW = `SRAL_LOS_WINDOW,
  parameter int MIN_TRANS = `SRAL_LOS_MIN_TRANS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Bit stream
  sral_bit_if.detector bus
);

  localparam int ZW = $clog2(ZERO_RUN + 1);
  localparam int TW = $clog2(WINDOW + 1);

  logic [ZW-1:0] zero_cnt;
  logic [TW-1:0] trans_cnt;
  logic [WINDOW-1:0] win;
  logic prev_bit;
  logic los;
  logic trans;

  assign trans = bus.bit_val ^ prev_bit;
  assign bus.los = los;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_cnt <= '0;
    end else if (bus.bit_stb) begin
      if (bus.bit_val) begin
        zero_cnt <= '0;
      end else if (zero_cnt != ZW'(ZERO_RUN)) begin
        zero_cnt <= zero_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_bit <= 1'b0;
      win <= '0;
      trans_cnt <= '0;
    end else if (bus.bit_stb) begin
      prev_bit <= bus.bit_val;
      win <= {win[WINDOW-2:0], trans};
      trans_cnt <= trans_cnt + TW'(trans) - TW'(win[WINDOW-1]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      los <= 1'b0;
    end else if (bus.los_disable) begin
      los <= 1'b0;
    end else if (bus.bit_stb && !bus.bit_val && zero_cnt == ZW'(ZERO_RUN - 1)) begin
      los <= 1'b1;
    end else if (los && trans_cnt >= TW'(MIN_TRANS)) begin
      los <= 1'b0;
    end
  end

  a_los_declare: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    bus.bit_stb && !bus.bit_val && !bus.los_disable && zero_cnt == ZW'(ZERO_RUN - 1)
    |=> los)
    else $error("loss of signal not declared after zero run");

  a_los_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(los) && !$past(bus.los_disable) |-> $past(trans_cnt) >= TW'(MIN_TRANS))
    else $error("loss of signal cleared without enough transitions");

  a_los_disabled: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    bus.los_disable |=> !los)
    else $error("loss of signal held while monitoring disabled");

  c_los_rise: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) $rose(los));
  c_los_fall: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(los) && !bus.los_disable);

endmodule : sral_los_detect

// File: sim/sral_framer_model.sv
// Line source and framer model: serial stream in, out-of-frame level, byte capture.
// Assumes the core clock oversamples the 800 ns link clock.
`timescale 1ns/10ps
module sral_framer_model (
  // Core clock
  input wire logic i_core_clk,
  // Serial line
  output logic o_ser_clk,
  output logic o_ser_data,
  // Framer control
  output logic o_oof,
  // Parallel bus
  input wire logic [7:0] i_byte,
  input wire logic i_byte_clk,
  input wire logic i_pulse
);
  bit q[$];
  logic [8:0] cap[$];
  logic prev_clk;

  // Recovered clock runs freely, unrelated phase
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_oof = 1'b0;
    prev_clk = 1'b0;
    #137;
    forever #400 o_ser_clk = ~o_ser_clk;
  end

  // Data moves mid-bit; fill toggles every bit
  always @(negedge o_ser_clk) begin
    if (q.size() != 0) o_ser_data <= q.pop_front();
    else o_ser_data <= ~o_ser_data;
  end

  // Byte taken at byte clock rise, pulse with it
  always @(posedge i_core_clk) begin
    prev_clk <= i_byte_clk;
    if (i_byte_clk && !prev_clk) cap.push_back({i_pulse, i_byte});
  end

  task automatic push_bit(input logic b, input int n);
    for (int i = 0; i < n; i++) q.push_back(b);
  endtask : push_bit

  task automatic push_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) q.push_back(b[i]);
  endtask : push_byte

  task automatic set_oof(input logic v);
    @(posedge i_core_clk);
    o_oof <= v;
  endtask : set_oof

  task automatic wait_idle(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 20000; i++) begin
      if (q.size() == 0) begin
        ok = 1'b1;
        break;
      end
      @(posedge i_core_clk);
    end
  endtask : wait_idle
endmodule : sral_framer_model

// File: sim/sral_top_tb.sv
// Self-checking bench for the receive alignment and loss-of-signal block.
// Assumes sral_framer_model feeds the line and captures bytes.
`timescale 1ns/10ps
module sral_top_tb;
  logic i_core_clk, i_arst_n, ser_clk, ser_data, out_of_frame_request, dis, ext_n, rate;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic wr, rd, bclk, pulse, sts12, los, irq;
  logic [7:0] pout;
  logic [8:0] acc;
  logic [7:0] frm[8] = '{8'hf6, 8'hf6, 8'hf6, 8'h28, 8'h28, 8'h28, 8'h5a, 8'hc3};
  int n_fail, num_checks, pcnt, pw, npul, idx;
  bit ok;

  sral_top sral_top_inst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_rx_serial_clk(ser_clk), .i_rx_serial_data(ser_data),
    .i_out_of_frame_request(out_of_frame_request), .i_los_detect_disable(dis),
    .i_optical_signal_lost_n(ext_n), .i_line_rate_select(rate), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rx_parallel_out(pout),
    .o_rx_byte_clock_out(bclk), .o_frame_sync_pulse(pulse), .o_line_rate_sts12(sts12),
    .o_los(los), .o_irq(irq));

  sral_framer_model sral_framer_model_inst (.i_core_clk(i_core_clk), .o_ser_clk(ser_clk),
    .o_ser_data(ser_data), .o_oof(out_of_frame_request), .i_byte(pout), .i_byte_clk(bclk), .i_pulse(pulse));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Frame pulse width in core cycles
  always @(posedge i_core_clk) begin
    if (pulse === 1'b1) pcnt <= pcnt + 1;
    else begin
      if (pcnt != 0) pw <= pcnt;
      pcnt <= 0;
    end
  end

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_core_clk);
    rd <= 1'b0;
    @(negedge i_core_clk);
    d = rdata;
    @(posedge i_core_clk);
  endtask : rd_reg

  task automatic idle();
    sral_framer_model_inst.wait_idle(ok);
    if (!ok) begin
      n_fail++;
      wrap_up();
    end
    repeat (12) @(posedge i_core_clk);
  endtask : idle

  task automatic wait_bytes(input int n);
    for (int i = 0; i < 2000; i++) begin
      if (sral_framer_model_inst.cap.size() >= n) return;
      @(posedge i_core_clk);
    end
    n_fail++;
    wrap_up();
  endtask : wait_bytes

  task automatic or_caps();
    acc = '0;
    foreach (sral_framer_model_inst.cap[j]) acc = acc | sral_framer_model_inst.cap[j];
  endtask : or_caps

  initial begin
    repeat (100000) @(posedge i_core_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    i_arst_n = 1'b0;
    {dis, rate, wr, rd} = '0;
    ext_n = 1'b1;
    addr = '0;
    wdata = '0;
    {n_fail, num_checks, pcnt, pw} = '0;
    repeat (20) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    // Reset values, refused places, read-only status
    rd_reg(4'h0, v);
    cmp(v, 32'h0000_0000);
    rd_reg(4'h2, v);
    cmp(v, 32'h0000_0000);
    wr_reg(4'h8, 32'h0000_0001);
    wr_reg(4'h0, 32'h0000_0007);
    rd_reg(4'h8, v);
    cmp(v, 32'h0000_0001);
    rd_reg(4'h4, v);
    cmp(v, 32'h0000_0000);
    rd_reg(4'h0, v);
    cmp(v, 32'h0000_0000);
    rate <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    cmp(sts12, 1'b1);
    rd_reg(4'hc, v);
    cmp(v[3], 1'b1);
    rate <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    cmp(sts12, 1'b0);
    // Frame search at every bit offset
    sral_framer_model_inst.set_oof(1'b1);
    for (int k = 0; k < 8; k++) begin
      sral_framer_model_inst.cap.delete();
      sral_framer_model_inst.push_bit(1'b1, k);
      foreach (frm[j]) sral_framer_model_inst.push_byte(frm[j]);
      wait_bytes(12);
      npul = 0;
      idx = 0;
      foreach (sral_framer_model_inst.cap[j]) begin
        if (sral_framer_model_inst.cap[j][8] === 1'b1) begin
          npul++;
          idx = j;
        end
      end
      cmp(npul, 1);
      cmp(sral_framer_model_inst.cap[idx][7:0], 8'h28);
      cmp(sral_framer_model_inst.cap[idx+1][7:0], 8'h5a);
      cmp(pw, 64);
    end
    // Searching, no loss, boundary locked
    rd_reg(4'hc, v);
    cmp(v[2:0], 3'h5);
    sral_framer_model_inst.set_oof(1'b0);
    cmp(irq, 1'b1);
    wr_reg(4'h4, 32'h0000_0001);
    repeat (2) @(posedge i_core_clk);
    cmp(irq, 1'b0);
    // External signal lost forces zero
    ext_n <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    sral_framer_model_inst.cap.delete();
    sral_framer_model_inst.push_bit(1'b1, 40);
    idle();
    or_caps();
    cmp(acc, 9'h000);
    ext_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    sral_framer_model_inst.push_bit(1'b1, 40);
    idle();
    cmp(pout, 8'hff);
    // Zero run one short, then full run
    wr_reg(4'h4, 32'h0000_0007);
    wr_reg(4'h8, 32'h0000_0002);
    sral_framer_model_inst.push_bit(1'b0, 127);
    sral_framer_model_inst.push_bit(1'b1, 1);
    idle();
    cmp(los, 1'b0);
    sral_framer_model_inst.push_bit(1'b0, 136);
    idle();
    cmp(los, 1'b1);
    cmp(irq, 1'b1);
    // Loss persists over a short burst, captures stay zero
    sral_framer_model_inst.cap.delete();
    sral_framer_model_inst.push_bit(1'b0, 40);
    sral_framer_model_inst.push_byte(8'h55);
    idle();
    cmp(los, 1'b1);
    cmp(pout, 8'h00);
    or_caps();
    cmp(acc, 9'h000);
    wr_reg(4'h4, 32'h0000_0002);
    repeat (2) @(posedge i_core_clk);
    cmp(irq, 1'b0);
    for (int i = 0; i < 300 && los !== 1'b0; i++) @(posedge i_core_clk);
    cmp(los, 1'b0);
    rd_reg(4'h0, v);
    cmp(v, 32'h0000_0004);
    // Disable drops a declared loss and stops monitoring
    sral_framer_model_inst.push_bit(1'b0, 130);
    idle();
    cmp(los, 1'b1);
    dis <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    cmp(los, 1'b0);
    sral_framer_model_inst.push_bit(1'b0, 140);
    idle();
    cmp(los, 1'b0);
    rd_reg(4'hc, v);
    cmp(v[4], 1'b0);
    wrap_up();
  end
endmodule : sral_top_tb
